/* sdram_port_pkg.sv */
// Constants and types for the registered memory module command port.
// Assumes one 250 MHz clock; all pins synchronous to it.
//
// Contract
// - Capture every input on rising clock edge
// - Command taken only with chip select low
// - Deselect ignores pins, running activity continues
// - Strobe levels together select the operation
// - Activate captures thirteen-bit row address
// - Column from address bits except ten
// - Precharge with bit ten high closes all
// - Precharge with bit ten low closes one
// - Bank number is binary, lsb select first
// - Clock gate high makes next edge valid
// - Clock gate low makes next edge invalid
// - Read mask high floats that byte lane
// - Write mask high keeps stored byte
// - Data bus is 64 data plus 8 check
// - First write beat comes with write command
// - Column commands may run back to back
package sdram_port_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_BANKS   = 4;
  localparam int ROW_W       = 13;
  localparam int COL_W       = 12;
  localparam int DQ_W        = 64;
  localparam int CB_W        = 8;
  localparam int BUS_W       = DQ_W + CB_W;
  localparam int LANES       = 8;
  localparam int LANE_BITS   = 8;
  localparam int PREALL_BIT  = 10;
  localparam int FIFO_DEPTH  = 32;

  // ==========================================================
  // Clock rate in MHz, timing in clock cycles
  localparam int CLK_MHZ     = 250;
  localparam int WR_LAT      = 0;
  localparam int RD_MASK_LAT = 2;
  localparam int CCD_MIN     = 1;

  // ==========================================================
  // Command codes as {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_MODE      = 3'h0;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_STOP      = 3'h6;
  localparam logic [2:0] CMD_IDLE      = 3'h7;

  // ==========================================================
  // Values after reset
  localparam logic       EDGE_OK_RST   = 1'b1;
  localparam logic [3:0] BANKS_RST     = 4'h0;

  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} burst_t;

endpackage : sdram_port_pkg

/* sdram_module_command_port.sv */
// Command port of a registered four-bank memory module, with a write
// buffer between the pins and the storage array.
// Assumes a controller on the pins, synchronous to mclk_in.
`timescale 1ns/1ps

// ============================================================
// Word FIFO
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sdram_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("word_fifo depth must be a power of two");
  end

  // Full when pointers differ only in the wrap bit
  assign in_ready_out  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
  assign out_valid_out = wr_ptr != rd_ptr;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = store[rd_ptr[PW-1:0]];

  // Pointers
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge mclk_in)
  begin
    if (push)
      store[wr_ptr[PW-1:0]] <= in_data_in;
  end

endmodule : word_fifo

// ============================================================
// Command port top
module sdram_module_command_port #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT   = 2,
  parameter int ROW_BITS  = 2,
  parameter int COL_BITS  = 4
) (
  // Clock and reset
  input  wire logic                              mclk_in,
  input  wire logic                              rst_n_in,
  // Command strobes
  input  wire logic                              cs_n_in,
  input  wire logic                              ras_n_in,
  input  wire logic                              cas_n_in,
  input  wire logic                              we_n_in,
  // Address and bank select
  input  wire logic [sdram_port_pkg::ROW_W-1:0]  addr_in,
  input  wire logic                              bank_sel_lsb_in,
  input  wire logic                              bank_sel_msb_in,
  // Clock gate and byte masks
  input  wire logic                              clk_gate_in,
  input  wire logic [sdram_port_pkg::LANES-1:0]  byte_lane_mask_in,
  // Data and check bits, two-way
  input  wire logic [sdram_port_pkg::BUS_W-1:0]  dq_in,
  output logic      [sdram_port_pkg::BUS_W-1:0]  dq_out,
  output logic      [sdram_port_pkg::BUS_W-1:0]  dq_oe_out,
  // Status
  output logic      [sdram_port_pkg::NUM_BANKS-1:0] bank_open_out,
  output logic                                   wr_buf_ready_out
);
  localparam int BUS_W = sdram_port_pkg::BUS_W;
  localparam int LANES = sdram_port_pkg::LANES;
  localparam int COL_W = sdram_port_pkg::COL_W;
  localparam int MLAT  = sdram_port_pkg::RD_MASK_LAT;
  localparam int AW    = 2 + ROW_BITS + COL_BITS;
  localparam int FW    = AW + LANES + BUS_W;
  localparam logic [COL_W-1:0] WRAP = COL_W'(BURST_LEN - 1);
  localparam logic [3:0] BEATS_LEFT = 4'(BURST_LEN - 1);

  if (!(BURST_LEN == 1 || BURST_LEN == 2 || BURST_LEN == 4 ||
        BURST_LEN == 8) || CAS_LAT < 2 || CAS_LAT > 3 ||
      COL_BITS < 3 || COL_BITS > COL_W || ROW_BITS < 1 ||
      ROW_BITS > sdram_port_pkg::ROW_W)
  begin : g_bad_params
    $error("sdram_module_command_port parameters out of range");
  end

  logic                   edge_ok;
  logic [2:0]             cmd;
  logic [1:0]             bank, burst_bank, beat_bank;
  logic [COL_W-1:0]       cmd_col, burst_col, beat_col, next_col;
  logic                   cmd_go, act_go, pre_go, rd_go, wr_go, stop_go;
  logic [3:0]             bank_open;
  logic [12:0]            open_row [sdram_port_pkg::NUM_BANKS];
  sdram_port_pkg::burst_t burst;
  logic [3:0]             burst_left;
  logic                   rd_beat, wr_beat;
  logic [AW-1:0]          beat_idx, drain_idx;
  logic [BUS_W-1:0]       mem [1 << AW];
  logic [FW-1:0]          push_word, drain_word;
  logic                   push_ready, drain_valid, drain_ready;
  logic [LANES-1:0]       drain_mask;
  logic [BUS_W-1:0]       drain_data, keep_bits, oe_bits;
  logic [BUS_W-1:0]       rd_data [CAS_LAT];
  logic [CAS_LAT-1:0]     rd_valid;
  logic                   rd_out_valid;
  logic [LANES-1:0]       rd_mask [MLAT];

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Edge qualification
  // Gate sampled now decides whether the following edge counts
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      edge_ok <= sdram_port_pkg::EDGE_OK_RST;
    else
      edge_ok <= clk_gate_in;
  end

  // ==========================================================
  // Command decode
  assign cmd     = {ras_n_in, cas_n_in, we_n_in};
  assign bank    = {bank_sel_msb_in, bank_sel_lsb_in};
  assign cmd_col = {addr_in[12:11], addr_in[9:0]};
  assign cmd_go  = edge_ok && !cs_n_in;
  assign act_go  = cmd_go && cmd == sdram_port_pkg::CMD_ACTIVATE;
  assign pre_go  = cmd_go && cmd == sdram_port_pkg::CMD_PRECHARGE;
  assign rd_go   = cmd_go && cmd == sdram_port_pkg::CMD_READ;
  assign wr_go   = cmd_go && cmd == sdram_port_pkg::CMD_WRITE;
  assign stop_go = cmd_go && cmd == sdram_port_pkg::CMD_STOP;

  // ==========================================================
  // Bank state: open flag and row per bank
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      bank_open <= sdram_port_pkg::BANKS_RST;
      for (int i = 0; i < sdram_port_pkg::NUM_BANKS; i++)
        open_row[i] <= '0;
    end
    else if (act_go)
    begin
      bank_open[bank] <= 1'b1;
      open_row[bank]  <= addr_in;
    end
    else if (pre_go)
    begin
      if (addr_in[sdram_port_pkg::PREALL_BIT])
        bank_open <= '0;
      else
        bank_open[bank] <= 1'b0;
    end
  end

  AST_ACT_ROW: assert property (
    act_go |=> bank_open[$past(bank)] &&
               open_row[$past(bank)] == $past(addr_in))
    else $error("activate did not capture row");

  AST_PRE_ALL: assert property (
    pre_go && addr_in[sdram_port_pkg::PREALL_BIT] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");

  AST_PRE_ONE: assert property (
    pre_go && !addr_in[sdram_port_pkg::PREALL_BIT] |=>
      bank_open == ($past(bank_open) & ~(4'h1 << $past(bank))))
    else $error("single precharge hit wrong banks");

  AST_DESEL_HOLDS: assert property (
    cs_n_in |=> $stable(bank_open))
    else $error("deselected cycle changed bank state");

  AST_GATE_VALID: assert property (
    clk_gate_in ##1 (!cs_n_in && !ras_n_in && cas_n_in && we_n_in)
      |=> bank_open[$past(bank)])
    else $error("activate after gate high not taken");

  // ==========================================================
  // Beat selection; a new column command cuts a running burst
  assign rd_beat   = rd_go || (edge_ok && !stop_go && !wr_go &&
                     burst == sdram_port_pkg::BURST_READ);
  assign wr_beat   = wr_go || (edge_ok && !stop_go && !rd_go &&
                     burst == sdram_port_pkg::BURST_WRITE);
  assign beat_bank = (rd_go || wr_go) ? bank : burst_bank;
  assign beat_col  = (rd_go || wr_go) ? cmd_col : burst_col;
  assign next_col  = (beat_col & ~WRAP) | ((beat_col + 12'h001) & WRAP);
  assign beat_idx  = {beat_bank, open_row[beat_bank][ROW_BITS-1:0],
                      beat_col[COL_BITS-1:0]};

  // Burst sequencer, runs on through deselect cycles
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      burst      <= sdram_port_pkg::BURST_IDLE;
      burst_left <= '0;
      burst_bank <= '0;
      burst_col  <= '0;
    end
    else if (edge_ok)
    begin
      if (rd_go || wr_go)
      begin
        burst      <= (BURST_LEN == 1) ? sdram_port_pkg::BURST_IDLE :
                      rd_go ? sdram_port_pkg::BURST_READ :
                              sdram_port_pkg::BURST_WRITE;
        burst_left <= BEATS_LEFT;
        burst_bank <= bank;
        burst_col  <= next_col;
      end
      else if (stop_go)
      begin
        burst      <= sdram_port_pkg::BURST_IDLE;
        burst_left <= '0;
      end
      else if (burst != sdram_port_pkg::BURST_IDLE)
      begin
        burst_left <= burst_left - 4'h1;
        burst_col  <= next_col;
        if (burst_left == 4'h1)
          burst <= sdram_port_pkg::BURST_IDLE;
      end
    end
  end

  AST_BURST_START: assert property (
    BURST_LEN > 1 && (rd_go || wr_go) |=> burst_left == BEATS_LEFT)
    else $error("column command did not restart burst");

  AST_DESEL_BURST_RUNS: assert property (
    cs_n_in && edge_ok && burst != sdram_port_pkg::BURST_IDLE
      |=> burst_left == $past(burst_left) - 4'h1)
    else $error("burst stalled on deselect");

  AST_SUSPEND_FREEZE: assert property (
    !edge_ok |=> $stable(burst_left) && $stable(rd_valid) &&
                 $stable(bank_open) && $stable(dq_oe_out))
    else $error("state moved on an invalid edge");

  // ==========================================================
  // Write buffer: write data is taken at the pins with no latency
  // and drained into the array when the read port is idle.
  // A read of a word still queued returns the older contents.
  assign push_word   = {beat_idx, byte_lane_mask_in, dq_in};
  assign drain_ready = !rd_beat;
  assign drain_idx   = drain_word[FW-1 -: AW];
  assign drain_mask  = drain_word[BUS_W +: LANES];
  assign drain_data  = drain_word[BUS_W-1:0];

  word_fifo #(
    .WIDTH (FW),
    .DEPTH (sdram_port_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_beat),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (drain_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_word)
  );

  AST_WR_SAME_CYCLE: assert property (
    wr_go && push_ready |=> drain_valid &&
      drain_word[BUS_W-1:0] == $past(dq_in))
    else $error("first write beat not taken with command");

  // Per-bit lane map: data byte n and check bit n share mask n
  for (genvar b = 0; b < BUS_W; b++)
  begin : g_lane_bits
    localparam int LANE = (b < sdram_port_pkg::DQ_W) ?
                          b / sdram_port_pkg::LANE_BITS :
                          b - sdram_port_pkg::DQ_W;
    assign keep_bits[b] = drain_mask[LANE];
    assign oe_bits[b]   = rd_out_valid &&
                          !rd_mask[MLAT-1][LANE];
  end

  // Array write, masked lanes keep their old contents
  always_ff @(posedge mclk_in)
  begin
    if (drain_valid && drain_ready)
      mem[drain_idx] <= (mem[drain_idx] & keep_bits) |
                        (drain_data & ~keep_bits);
  end

  // ==========================================================
  // Read pipeline, frozen on invalid edges like a suspended clock
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      rd_valid <= '0;
      for (int k = 0; k < CAS_LAT; k++)
        rd_data[k] <= '0;
      for (int k = 0; k < MLAT; k++)
        rd_mask[k] <= '0;
    end
    else if (edge_ok)
    begin
      rd_valid   <= {rd_valid[CAS_LAT-2:0], rd_beat};
      rd_data[0] <= mem[beat_idx];
      for (int k = 1; k < CAS_LAT; k++)
        rd_data[k] <= rd_data[k-1];
      rd_mask[0] <= byte_lane_mask_in;
      for (int k = 1; k < MLAT; k++)
        rd_mask[k] <= rd_mask[k-1];
    end
  end

  assign rd_out_valid     = rd_valid[CAS_LAT-1];
  assign dq_out           = rd_data[CAS_LAT-1];
  assign dq_oe_out        = oe_bits;
  assign bank_open_out    = bank_open;
  assign wr_buf_ready_out = push_ready;

  AST_READ_LAT: assert property (
    CAS_LAT == 2 && rd_go ##1 edge_ok |=> rd_out_valid)
    else $error("read data late or missing");

  AST_RD_MASK_OE: assert property (
    edge_ok && byte_lane_mask_in[0] ##1 edge_ok |=> !dq_oe_out[0])
    else $error("masked lane drove read data");

  // Main scenarios
  COV_BACK_TO_BACK_READ: cover property (rd_go ##1 rd_go);
  COV_WRITE_BURST: cover property (wr_go ##1 wr_beat ##1 wr_beat);
  COV_PRECHARGE_ALL: cover property (
    pre_go && addr_in[sdram_port_pkg::PREALL_BIT]);
  COV_SUSPEND_IN_BURST: cover property (
    burst != sdram_port_pkg::BURST_IDLE && !edge_ok);

endmodule : sdram_module_command_port

/* sdram_ctrl_model.sv */
// Memory controller model that drives every command pin of the module.
// Assumes the bench calls drive() once per clock, after reset is released.
`timescale 1ns/1ps

// ============================================================
// Controller model
module sdram_ctrl_model (
  // Clock
  input  wire logic        mclk_in,
  // Pins toward the module
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic [12:0]      addr_out,
  output logic             bank_sel_lsb_out,
  output logic             bank_sel_msb_out,
  output logic             clk_gate_out,
  output logic [7:0]       byte_lane_mask_out,
  output logic [71:0]      dq_out
);
  // Pins at rest while reset is held
  initial
  begin
    cs_n_out           = 1'b1;
    {ras_n_out, cas_n_out, we_n_out} = sdram_port_pkg::CMD_IDLE;
    addr_out           = 13'h0000;
    bank_sel_lsb_out   = 1'b0;
    bank_sel_msb_out   = 1'b0;
    clk_gate_out       = 1'b1;
    byte_lane_mask_out = 8'h00;
    dq_out             = 72'h0;
  end

  // One clock of pin values, launched just after the rising edge
  task automatic drive(input logic cs_n, input logic [2:0] cmd,
                       input logic [1:0] bank, input logic [12:0] addr,
                       input logic wr, input logic [71:0] data,
                       input logic [7:0] mask, input logic gate);
    @(posedge mclk_in);
    cs_n_out                         <= cs_n;
    {ras_n_out, cas_n_out, we_n_out} <= cmd;
    addr_out                         <= addr;
    {bank_sel_msb_out, bank_sel_lsb_out} <= bank;
    byte_lane_mask_out               <= mask;
    clk_gate_out                     <= gate;
    // Released bus toggles so stale data never looks valid
    dq_out <= wr ? data : ~dq_out;
  endtask : drive
endmodule : sdram_ctrl_model

/* sdram_module_command_port_tb.sv */
// Self-checking bench for the memory module command port and its buffer.
// Assumes sdram_ctrl_model drives the pins; a reference array predicts.
`timescale 1ns/1ps
module sdram_module_command_port_tb;
  // ==========================================================
  // Pins and bench state
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cs_n_in, ras_n_in, cas_n_in, we_n_in;
  logic [12:0] addr_in;
  logic        bank_sel_lsb_in, bank_sel_msb_in, clk_gate_in;
  logic [7:0]  byte_lane_mask_in;
  logic [71:0] dq_in, dq_out, dq_oe_out;
  logic [3:0]  bank_open_out, opened;
  logic        wr_buf_ready_out;
  logic [71:0] ref_mem [256];
  logic [12:0] open_row [4];
  int          errors, num_checks;
  int          seed = 32'h4ff66d37;

  // Free-running 250 MHz clock
  always #2 mclk_in = ~mclk_in;

  // ==========================================================
  // Instances
  sdram_ctrl_model u_ctrl (.mclk_in(mclk_in), .cs_n_out(cs_n_in),
    .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in),
    .addr_out(addr_in), .bank_sel_lsb_out(bank_sel_lsb_in),
    .bank_sel_msb_out(bank_sel_msb_in), .clk_gate_out(clk_gate_in),
    .byte_lane_mask_out(byte_lane_mask_in), .dq_out(dq_in));
  sdram_module_command_port DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in),
    .we_n_in(we_n_in), .addr_in(addr_in), .bank_sel_lsb_in(bank_sel_lsb_in),
    .bank_sel_msb_in(bank_sel_msb_in), .clk_gate_in(clk_gate_in),
    .byte_lane_mask_in(byte_lane_mask_in), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .bank_open_out(bank_open_out),
    .wr_buf_ready_out(wr_buf_ready_out));

  // ==========================================================
  // Helpers
  function automatic logic [71:0] r72();
    logic [95:0] w;
    w = {$random(seed), $random(seed), $random(seed)};
    return w[71:0];
  endfunction : r72

  // Unmasked lanes: eight data bits plus one check bit each
  function automatic logic [71:0] lanes(input logic [7:0] mk);
    logic [71:0] v;
    v = 72'h0;
    for (int k = 0; k < 8; k++)
    begin
      v[8*k +: 8] = {8{~mk[k]}};
      v[64+k]     = ~mk[k];
    end
    return v;
  endfunction : lanes

  // Word index with the burst wrapping inside its aligned block of four
  function automatic logic [7:0] idx(input logic [1:0] b,
                                     input logic [12:0] a, input int j);
    logic [1:0] lo;
    lo = a[1:0] + j[1:0];
    return {b, open_row[b][1:0], a[3:2], lo};
  endfunction : idx

  task automatic check(input string what, input logic [71:0] seen,
                       input logic [71:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Deselected clock with junk on every ignored pin
  task automatic desel(input logic [7:0] mk);
    logic [31:0] r;
    r = $random(seed);
    u_ctrl.drive(1'b1, r[2:0], r[4:3], r[17:5], 1'b0, 72'h0, mk, 1'b1);
  endtask : desel

  task automatic bank_cmd(input logic cs_n, input logic [2:0] cmd,
                          input logic [1:0] b, input logic [12:0] a,
                          input logic gate);
    u_ctrl.drive(cs_n, cmd, b, a, 1'b0, 72'h0, 8'h00, gate);
    desel(8'h00);
    desel(8'h00);
    #1;
    check("bank_open", {68'h0, bank_open_out}, {68'h0, opened});
  endtask : bank_cmd

  task automatic act(input logic [1:0] b, input logic [12:0] row);
    open_row[b] = row;
    opened[b]   = 1'b1;
    bank_cmd(1'b0, sdram_port_pkg::CMD_ACTIVATE, b, row, 1'b1);
  endtask : act

  task automatic pre(input logic [1:0] b, input logic all);
    logic [12:0] a;
    a     = 13'(r72());
    a[10] = all;
    if (all)
      opened = 4'h0;
    else
      opened[b] = 1'b0;
    bank_cmd(1'b0, sdram_port_pkg::CMD_PRECHARGE, b, a, 1'b1);
  endtask : pre

  // Write burst; mask kept clear when full is set
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input bit full);
    logic [71:0] d;
    logic [7:0]  mk;
    for (int j = 0; j < 4; j++)
    begin
      d  = r72();
      mk = full ? 8'h00 : 8'($random(seed));
      if (j == 0)
        u_ctrl.drive(1'b0, sdram_port_pkg::CMD_WRITE, b, a, 1'b1, d, mk, 1'b1);
      else
        u_ctrl.drive(1'b1, sdram_port_pkg::CMD_IDLE, b, a, 1'b1, d, mk, 1'b1);
      ref_mem[idx(b, a, j)] = (ref_mem[idx(b, a, j)] & ~lanes(mk)) |
                              (d & lanes(mk));
      #1;
      check("wr_buf_ready", {71'h0, wr_buf_ready_out}, 72'h1);
    end
    repeat (2) desel(8'h00);
  endtask : wr

  // Read at a1; mode 1 cuts it with a read at a2, mode 2 with burst stop
  task automatic rd(input logic [1:0] b, input logic [12:0] a1,
                    input logic [12:0] a2, input int mode);
    logic [7:0]  mk [9];
    logic [71:0] oe;
    bit          ok;
    for (int i = 0; i < 9; i++)
    begin
      mk[i] = 8'($random(seed));
      if (i == 0)
        u_ctrl.drive(1'b0, sdram_port_pkg::CMD_READ, b, a1, 1'b0, 72'h0,
                     mk[i], 1'b1);
      else if (i == 1 && mode != 0)
        u_ctrl.drive(1'b0, mode == 1 ? sdram_port_pkg::CMD_READ :
                     sdram_port_pkg::CMD_STOP, b, a2, 1'b0, 72'h0, mk[i], 1'b1);
      else
        desel(mk[i]);
      #1;
      ok = mode == 1 ? i <= 6 : (mode == 2 ? i == 2 : i <= 5);
      if (i >= 2)
      begin
        oe = ok ? lanes(mk[i-2]) : 72'h0;
        check("dq_oe", dq_oe_out, oe);
        if (mode == 1 && i >= 3)
          check("dq", dq_out & oe, ref_mem[idx(b, a2, i-3)] & oe);
        else
          check("dq", dq_out & oe, ref_mem[idx(b, a1, i-2)] & oe);
      end
    end
  endtask : rd

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [1:0]  b;
    logic [12:0] a, a2;
    opened = 4'h0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    check("rst_oe", dq_oe_out, 72'h0);
    check("rst_bank", {68'h0, bank_open_out}, 72'h0);
    check("rst_ready", {71'h0, wr_buf_ready_out}, 72'h1);
    // Mode set and refresh are each followed by an idle clock
    u_ctrl.drive(1'b0, sdram_port_pkg::CMD_MODE, 2'h0, 13'h0, 1'b0, 72'h0,
                 8'h00, 1'b1);
    desel(8'h00);
    u_ctrl.drive(1'b0, sdram_port_pkg::CMD_REFRESH, 2'h0, 13'h0, 1'b0, 72'h0,
                 8'h00, 1'b1);
    desel(8'h00);
    for (int i = 0; i < 4; i++)
      act(i[1:0], 13'(r72()));
    pre(2'h2, 1'b0);
    bank_cmd(1'b1, sdram_port_pkg::CMD_ACTIVATE, 2'h2, 13'(r72()),
             1'b1);
    u_ctrl.drive(1'b1, sdram_port_pkg::CMD_IDLE, 2'h0, 13'h0, 1'b0, 72'h0,
                 8'h00, 1'b0);
    bank_cmd(1'b0, sdram_port_pkg::CMD_ACTIVATE, 2'h2, 13'(r72()),
             1'b0);
    act(2'h2, 13'(r72()));
    pre(2'($random(seed)), 1'b1);
    for (int i = 0; i < 4; i++)
      act(i[1:0], 13'(r72()));
    for (int i = 0; i < 8; i++)
    begin
      b  = 2'($random(seed));
      a  = 13'(r72());
      a2 = 13'(r72());
      a2[3:2] = a[3:2];
      pre(b, 1'b0);
      act(b, 13'(r72()));
      wr(b, a, 1'b1);
      wr(b, a2, 1'b0);
      rd(b, a, a2, 0);
      rd(b, a2, a, 1);
      rd(b, a, a2, 2);
    end
    // Buffer never backs up: every queued beat drains on a free cycle
    check("end_ready", {71'h0, wr_buf_ready_out}, 72'h1);
    check("end_bank", {68'h0, bank_open_out}, {68'h0, opened});
    check("end_oe", dq_oe_out, 72'h0);
    wrap_up();
  end

  // Watchdog against a hang
  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule : sdram_module_command_port_tb
